// File: design/wcr_config_bank.sv
`timescale 1ns/1ps
// Overview of operation
// (RULE1) calibration high byte readable, cleared on reset
// (RULE2) calibration low byte readable, cleared on reset
// (RULE3) filter select 00/01/10 gives 8/16/32
// (RULE4) select 11 adapts constant to edge spacing
// (RULE5) control one bit 0 enables recovery
// (RULE6) reserved control bits always read zero
// (RULE7) clock select picks 80/40/20/10 MHz
// (RULE8) control one resets to 04, restart keeps fields
// (RULE9) upper limit a8, high bit times clamped
// (RULE10) lower limit register resets to 98
// (RULE11) low bit times clamped to lower limit
// (RULE12) software picks recommended bit time limit sets
// (RULE13) software avoids clock choices that overflow
// (RULE14) software avoids clock choices lacking precision
// (RULE15) control two resets zero, restart keeps select
// (RULE16) one 16-bit frame: address, mode, data
// (RULE17) writes to read-only or reserved bits ignored
module wcr_config_bank (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        soft_reset,
  input  wire logic        restart,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_en,
  input  wire logic        cal_valid,
  input  wire logic [15:0] cal_value,
  input  wire logic [3:0]  edge_spacing,
  input  wire logic [7:0]  measured_bit_time,
  output logic             recovery_enable_bit,
  output logic [1:0]       recovery_clock_select,
  output logic [6:0]       recovery_clock_mhz,
  output logic [5:0]       filter_time_constant,
  output logic [7:0]       clamped_bit_time
);

  logic [1:0]          rst_sync;
  logic                rst_n;
  wcr_pkg::wcr_state_t s;
  wcr_pkg::wcr_state_t next_s;
  logic [5:0]          calc_time_constant;
  logic [7:0]          calc_bit_time;
  logic                cs_new;
  logic                sclk_new;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                frame_end;
  logic                wr_fire;
  logic [6:0]          wr_addr;
  logic [7:0]          wr_data;
  logic [15:0]         rx_now;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  wcr_recovery_calc u_calc (
    .filter_constant_select (s.regs.ctrl_one[3:2]),
    .edge_spacing           (edge_spacing),
    .recovery_enable_bit    (s.regs.ctrl_one[wcr_pkg::POS_ENABLE]),
    .measured_bit_time      (measured_bit_time),
    .upper_limit_value      (s.regs.limit_high),
    .lower_limit_value      (s.regs.limit_low),
    .time_constant          (calc_time_constant),
    .bit_time               (calc_bit_time)
  );

  function automatic logic [7:0] read_reg(input logic [6:0] addr,
                                          input wcr_pkg::wcr_regs_t r);
    case (addr)
      wcr_pkg::ADDR_CAL_HIGH:   read_reg = r.cal_high; // RULE1
      wcr_pkg::ADDR_CAL_LOW:    read_reg = r.cal_low; // RULE2
      wcr_pkg::ADDR_CTRL_ONE:   read_reg = r.ctrl_one & wcr_pkg::MASK_CTRL_ONE; // RULE6
      wcr_pkg::ADDR_CTRL_TWO:   read_reg = r.ctrl_two & wcr_pkg::MASK_CTRL_TWO; // RULE6
      wcr_pkg::ADDR_LIMIT_HIGH: read_reg = r.limit_high;
      wcr_pkg::ADDR_LIMIT_LOW:  read_reg = r.limit_low;
      default:                  read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // a pin level changes once the second and third stages agree
  assign cs_new    = (s.cs_sync[1] == s.cs_sync[2]) ? s.cs_sync[2] : s.cs_lvl;
  assign sclk_new  = (s.sclk_sync[1] == s.sclk_sync[2]) ? s.sclk_sync[2] : s.sclk_lvl;
  assign sclk_rise = (s.frame == wcr_pkg::WCR_FRAME) && !s.sclk_lvl && sclk_new;
  assign sclk_fall = (s.frame == wcr_pkg::WCR_FRAME) && s.sclk_lvl && !sclk_new;
  assign frame_end = (s.frame == wcr_pkg::WCR_FRAME) && cs_new;
  // only a complete 16-bit frame with the mode bit set writes
  assign wr_fire   = frame_end && (s.bit_count == wcr_pkg::FRAME_BITS) &&
                     s.rx[wcr_pkg::POS_MODE]; // RULE16
  assign wr_addr   = s.rx[6:0];
  assign wr_data   = s.rx[15:8];
  assign rx_now    = s.rx | (16'h0001 << s.bit_count[3:0]);

  always_comb begin
    next_s = s;
    next_s.cs_sync   = {s.cs_sync[1:0], spi_cs_n};
    next_s.sclk_sync = {s.sclk_sync[1:0], spi_sclk};
    next_s.sdi_sync  = {s.sdi_sync[1:0], spi_sdi};
    next_s.cs_lvl    = cs_new;
    next_s.sclk_lvl  = sclk_new;
    next_s.sdi_lvl   = (s.sdi_sync[1] == s.sdi_sync[2]) ? s.sdi_sync[2] : s.sdi_lvl;

    case (s.frame)
      wcr_pkg::WCR_IDLE: begin
        next_s.sdo_en = 1'b0;
        if (!cs_new) begin
          next_s.frame     = wcr_pkg::WCR_FRAME;
          next_s.bit_count = 5'h00;
          next_s.rx        = 16'h0000;
          next_s.tx        = 16'h0000;
          next_s.sdo       = 1'b0;
          next_s.sdo_en    = 1'b1;
        end
      end
      wcr_pkg::WCR_FRAME: begin
        if (frame_end) begin
          next_s.frame  = wcr_pkg::WCR_IDLE;
          next_s.sdo_en = 1'b0;
          next_s.sdo    = 1'b0;
        end else if (sclk_rise) begin
          // data arrives least significant bit first
          if (s.bit_count < wcr_pkg::FRAME_BITS) begin
            if (s.sdi_lvl) begin
              next_s.rx = rx_now;
            end
            next_s.bit_count = s.bit_count + 5'h01;
          end
          if (s.bit_count == wcr_pkg::ADDR_DONE_BIT) begin
            next_s.tx[15:8] = read_reg(s.rx[6:0], s.regs); // RULE16
          end
        end else if (sclk_fall) begin
          next_s.sdo = s.tx[s.bit_count[3:0]];
        end
      end
      default: begin
        next_s.frame  = wcr_pkg::WCR_IDLE;
        next_s.sdo_en = 1'b0;
      end
    endcase

    if (soft_reset) begin
      next_s.regs.cal_high   = wcr_pkg::RST_CAL; // RULE1
      next_s.regs.cal_low    = wcr_pkg::RST_CAL; // RULE2
      next_s.regs.ctrl_one   = wcr_pkg::RST_CTRL_ONE; // RULE8
      next_s.regs.ctrl_two   = wcr_pkg::RST_CTRL_TWO; // RULE15
      next_s.regs.limit_high = wcr_pkg::RST_LIMIT_HIGH; // RULE9
      next_s.regs.limit_low  = wcr_pkg::RST_LIMIT_LOW; // RULE10
    end else if (restart) begin
      next_s.regs.ctrl_one = s.regs.ctrl_one & wcr_pkg::MASK_CTRL_ONE; // RULE8
      next_s.regs.ctrl_two = s.regs.ctrl_two & wcr_pkg::MASK_CTRL_TWO; // RULE15
    end else if (wr_fire) begin
      case (wr_addr)
        wcr_pkg::ADDR_CTRL_ONE:   next_s.regs.ctrl_one   = wr_data & wcr_pkg::MASK_CTRL_ONE; // RULE5
        wcr_pkg::ADDR_CTRL_TWO:   next_s.regs.ctrl_two   = wr_data & wcr_pkg::MASK_CTRL_TWO; // RULE7
        wcr_pkg::ADDR_LIMIT_HIGH: next_s.regs.limit_high = wr_data; // RULE9
        wcr_pkg::ADDR_LIMIT_LOW:  next_s.regs.limit_low  = wr_data; // RULE10
        default: begin
          next_s.regs = s.regs; // RULE17
        end
      endcase
    end

    // calibration after writes so a write in the same cycle cannot drop it
    if (cal_valid && !soft_reset) begin
      next_s.regs.cal_high = cal_value[15:8]; // RULE1
      next_s.regs.cal_low  = cal_value[7:0]; // RULE2
    end

    case (s.regs.ctrl_two[1:0])
      2'h0:    next_s.clock_mhz = wcr_pkg::CLK_MHZ_SEL0; // RULE7
      2'h1:    next_s.clock_mhz = wcr_pkg::CLK_MHZ_SEL1; // RULE7
      2'h2:    next_s.clock_mhz = wcr_pkg::CLK_MHZ_SEL2; // RULE7
      default: next_s.clock_mhz = wcr_pkg::CLK_MHZ_SEL3; // RULE7
    endcase
    next_s.time_constant = calc_time_constant; // RULE3
    next_s.bit_time      = calc_bit_time; // RULE9
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.cs_sync         <= wcr_pkg::SYNC_HIGH;
      s.sclk_sync       <= wcr_pkg::SYNC_LOW;
      s.sdi_sync        <= wcr_pkg::SYNC_LOW;
      s.cs_lvl          <= 1'b1;
      s.sclk_lvl        <= 1'b0;
      s.sdi_lvl         <= 1'b0;
      s.frame           <= wcr_pkg::WCR_IDLE;
      s.bit_count       <= 5'h00;
      s.rx              <= 16'h0000;
      s.tx              <= 16'h0000;
      s.sdo             <= 1'b0;
      s.sdo_en          <= 1'b0;
      s.regs.cal_high   <= wcr_pkg::RST_CAL;
      s.regs.cal_low    <= wcr_pkg::RST_CAL;
      s.regs.ctrl_one   <= wcr_pkg::RST_CTRL_ONE;
      s.regs.ctrl_two   <= wcr_pkg::RST_CTRL_TWO;
      s.regs.limit_high <= wcr_pkg::RST_LIMIT_HIGH;
      s.regs.limit_low  <= wcr_pkg::RST_LIMIT_LOW;
      s.time_constant   <= wcr_pkg::TC_16;
      s.bit_time        <= 8'h00;
      s.clock_mhz       <= wcr_pkg::CLK_MHZ_SEL0;
    end else begin
      s <= next_s;
    end
  end

  assign spi_sdo               = s.sdo;
  assign spi_sdo_en            = s.sdo_en;
  assign recovery_enable_bit   = s.regs.ctrl_one[wcr_pkg::POS_ENABLE]; // RULE5
  assign recovery_clock_select = s.regs.ctrl_two[1:0]; // RULE7
  assign recovery_clock_mhz    = s.clock_mhz;
  assign filter_time_constant  = s.time_constant;
  assign clamped_bit_time      = s.bit_time;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_cal_soft_clear: assert property ( // RULE1
    soft_reset |=> s.regs.cal_high == 8'h00 && s.regs.cal_low == 8'h00)
    else $error("calibration bytes not cleared by soft reset");

  chk_cal_write_ignored: assert property ( // RULE17
    wr_fire && !cal_valid && !soft_reset && wr_addr[6:1] == 6'h1d
    |=> $stable(s.regs.cal_high) && $stable(s.regs.cal_low))
    else $error("calibration byte changed by a write");

  chk_reserved_zero: assert property ( // RULE6
    s.regs.ctrl_one[7:4] == 4'h0 && !s.regs.ctrl_one[1] && s.regs.ctrl_two[7:2] == 6'h00)
    else $error("reserved control bit set");

  chk_enable_follows: assert property ( // RULE5
    wr_fire && !soft_reset && !restart && wr_addr == 7'h3c
    |=> recovery_enable_bit == $past(wr_data[0]))
    else $error("enable bit did not follow write");

  chk_soft_values: assert property ( // RULE8
    soft_reset |=> s.regs.ctrl_one == 8'h04 && s.regs.ctrl_two == 8'h00 &&
                   s.regs.limit_high == 8'ha8 && s.regs.limit_low == 8'h98)
    else $error("wrong soft reset values");

  chk_restart_keeps: assert property ( // RULE15
    restart && !soft_reset |=> $stable(s.regs.ctrl_one) && $stable(s.regs.ctrl_two) &&
                               $stable(s.regs.limit_high))
    else $error("restart changed kept fields");

  chk_filter_fixed: assert property ( // RULE3
    s.regs.ctrl_one[3:2] == 2'h2 |=> filter_time_constant == 6'h20)
    else $error("filter select 10 did not give 32");

  chk_adapt_long: assert property ( // RULE4
    s.regs.ctrl_one[3:2] == 2'h3 && edge_spacing == 4'h9 |=> filter_time_constant == 6'h08)
    else $error("adaptive filter wrong for long spacing");

  chk_clamp_upper: assert property ( // RULE9
    recovery_enable_bit && measured_bit_time > s.regs.limit_high
    |=> clamped_bit_time == $past(s.regs.limit_high))
    else $error("bit time above upper limit not clamped");

  chk_clamp_lower: assert property ( // RULE11
    recovery_enable_bit && measured_bit_time < s.regs.limit_low &&
    s.regs.limit_low <= s.regs.limit_high
    |=> clamped_bit_time == $past(s.regs.limit_low))
    else $error("bit time below lower limit not clamped");

  chk_clock_slow: assert property ( // RULE7
    recovery_clock_select == 2'h3 |=> recovery_clock_mhz == 7'h0a)
    else $error("clock select 11 not 10 MHz");

  chk_short_frame: assert property ( // RULE16
    frame_end && s.bit_count != 5'h10 && !soft_reset && !restart
    |=> $stable(s.regs.ctrl_one) && $stable(s.regs.limit_low))
    else $error("short frame wrote a register");

  chk_cal_load: assert property ( // RULE2
    cal_valid && !soft_reset
    |=> s.regs.cal_high == $past(cal_value[15:8]) && s.regs.cal_low == $past(cal_value[7:0]))
    else $error("calibration result not loaded");

  chk_sdo_en_start: assert property ( // RULE16
    s.frame == wcr_pkg::WCR_IDLE && !cs_new |=> spi_sdo_en)
    else $error("data out not enabled at frame start");

  chk_limit_low_write: assert property ( // RULE10
    wr_fire && !soft_reset && !restart && wr_addr == 7'h3f
    |=> s.regs.limit_low == $past(wr_data))
    else $error("lower limit did not take write");

  chk_limit_high_write: assert property ( // RULE9
    wr_fire && !soft_reset && !restart && wr_addr == 7'h3e
    |=> s.regs.limit_high == $past(wr_data))
    else $error("upper limit did not take write");

  cov_clamp_upper: cover property (recovery_enable_bit && measured_bit_time > s.regs.limit_high);
  cov_write_frame: cover property (wr_fire);
  cov_read_frame:  cover property (frame_end && s.bit_count == 5'h10 && !s.rx[7]);
  cov_restart:     cover property (restart && recovery_enable_bit);
  cov_adapt:       cover property (s.regs.ctrl_one[3:2] == 2'h3 && edge_spacing == 4'h2);

endmodule : wcr_config_bank

// File: design/wcr_recovery_calc.sv
`timescale 1ns/1ps
module wcr_recovery_calc (
  input  wire logic [1:0] filter_constant_select,
  input  wire logic [3:0] edge_spacing,
  input  wire logic       recovery_enable_bit,
  input  wire logic [7:0] measured_bit_time,
  input  wire logic [7:0] upper_limit_value,
  input  wire logic [7:0] lower_limit_value,
  output logic      [5:0] time_constant,
  output logic      [7:0] bit_time
);

  always_comb begin
    case (filter_constant_select)
      wcr_pkg::FILT_SEL_8:  time_constant = wcr_pkg::TC_8;  // RULE3
      wcr_pkg::FILT_SEL_16: time_constant = wcr_pkg::TC_16; // RULE3
      wcr_pkg::FILT_SEL_32: time_constant = wcr_pkg::TC_32; // RULE3
      default: begin
        // adaptive: spacing outside 2..10 bits keeps the middle constant
        if (edge_spacing >= wcr_pkg::SPACE_SHORT_MIN &&
            edge_spacing <= wcr_pkg::SPACE_SHORT_MAX) begin
          time_constant = wcr_pkg::TC_32; // RULE4
        end else if (edge_spacing > wcr_pkg::SPACE_MID_MAX &&
                     edge_spacing <= wcr_pkg::SPACE_LONG_MAX) begin
          time_constant = wcr_pkg::TC_8; // RULE4
        end else begin
          time_constant = wcr_pkg::TC_16; // RULE4
        end
      end
    endcase
  end

  always_comb begin
    bit_time = measured_bit_time;
    if (recovery_enable_bit) begin
      if (measured_bit_time > upper_limit_value) begin
        bit_time = upper_limit_value; // RULE9
      end else if (measured_bit_time < lower_limit_value) begin
        bit_time = lower_limit_value; // RULE11
      end
    end
  end

endmodule : wcr_recovery_calc

// File: inc/wcr_pkg.sv
package wcr_pkg;

  // register addresses on the 7-bit serial address field
  localparam logic [6:0] ADDR_CAL_HIGH   = 7'h3a;
  localparam logic [6:0] ADDR_CAL_LOW    = 7'h3b;
  localparam logic [6:0] ADDR_CTRL_ONE   = 7'h3c;
  localparam logic [6:0] ADDR_CTRL_TWO   = 7'h3d;
  localparam logic [6:0] ADDR_LIMIT_HIGH = 7'h3e;
  localparam logic [6:0] ADDR_LIMIT_LOW  = 7'h3f;

  // power-on and soft reset values
  localparam logic [7:0] RST_CAL         = 8'h00;
  localparam logic [7:0] RST_CTRL_ONE    = 8'h04;
  localparam logic [7:0] RST_CTRL_TWO    = 8'h00;
  localparam logic [7:0] RST_LIMIT_HIGH  = 8'ha8;
  localparam logic [7:0] RST_LIMIT_LOW   = 8'h98;

  // writable bits; the same bits survive a restart
  localparam logic [7:0] MASK_CTRL_ONE   = 8'h0d;
  localparam logic [7:0] MASK_CTRL_TWO   = 8'h03;

  // field positions
  localparam int unsigned POS_ENABLE     = 0;
  localparam int unsigned POS_FILT_LO    = 2;
  localparam int unsigned POS_MODE       = 7;

  // filter selection codes and time constants
  localparam logic [1:0] FILT_SEL_8      = 2'h0;
  localparam logic [1:0] FILT_SEL_16     = 2'h1;
  localparam logic [1:0] FILT_SEL_32     = 2'h2;
  localparam logic [1:0] FILT_SEL_ADAPT  = 2'h3;
  localparam logic [5:0] TC_8            = 6'h08;
  localparam logic [5:0] TC_16           = 6'h10;
  localparam logic [5:0] TC_32           = 6'h20;

  // falling edge spacing bounds in bits for the adaptive filter
  localparam logic [3:0] SPACE_SHORT_MIN = 4'h2;
  localparam logic [3:0] SPACE_SHORT_MAX = 4'h3;
  localparam logic [3:0] SPACE_MID_MAX   = 4'h8;
  localparam logic [3:0] SPACE_LONG_MAX  = 4'ha;

  // recovery input clock in MHz per selection code
  localparam logic [6:0] CLK_MHZ_SEL0    = 7'h50;
  localparam logic [6:0] CLK_MHZ_SEL1    = 7'h28;
  localparam logic [6:0] CLK_MHZ_SEL2    = 7'h14;
  localparam logic [6:0] CLK_MHZ_SEL3    = 7'h0a;

  // serial frame layout
  localparam logic [4:0] FRAME_BITS      = 5'h10;
  localparam logic [4:0] ADDR_DONE_BIT   = 5'h07;

  // pin synchroniser values after reset
  localparam logic [2:0] SYNC_HIGH       = 3'h7;
  localparam logic [2:0] SYNC_LOW        = 3'h0;

  typedef enum logic {
    WCR_IDLE  = 1'b0,
    WCR_FRAME = 1'b1
  } wcr_frame_t;

  typedef struct packed {
    logic [7:0] cal_high;
    logic [7:0] cal_low;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] limit_high;
    logic [7:0] limit_low;
  } wcr_regs_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [2:0] sdi_sync;
    logic       cs_lvl;
    logic       sclk_lvl;
    logic       sdi_lvl;
    wcr_frame_t frame;
    logic [4:0] bit_count;
    logic [15:0] rx;
    logic [15:0] tx;
    logic       sdo;
    logic       sdo_en;
    wcr_regs_t  regs;
    logic [5:0] time_constant;
    logic [7:0] bit_time;
    logic [6:0] clock_mhz;
  } wcr_state_t;

endpackage : wcr_pkg

// File: testbench/wake_clock_recovery_config_bench.sv
`timescale 1ns/1ps
module wake_clock_recovery_config_bench;
  logic        clk;
  logic        reset_n;
  logic        soft_reset;
  logic        restart;
  logic        cal_valid;
  logic        spi_cs_n;
  logic        spi_sclk;
  logic        spi_sdi;
  logic        spi_sdo;
  logic        spi_sdo_en;
  logic        rd_valid;
  logic        recovery_enable_bit;
  logic [15:0] cal_value;
  logic [3:0]  edge_spacing;
  logic [7:0]  measured_bit_time;
  logic [7:0]  clamped_bit_time;
  logic [7:0]  rd_data;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [7:0]  v;
  logic [1:0]  recovery_clock_select;
  logic [6:0]  recovery_clock_mhz;
  logic [5:0]  filter_time_constant;
  logic [7:0]  exp_q[$];
  int          miscompares = 0;
  int          tests_run = 0;

  wcr_config_bank DUT (
    .clk                   (clk),
    .reset_n               (reset_n),
    .soft_reset            (soft_reset),
    .restart               (restart),
    .spi_cs_n              (spi_cs_n),
    .spi_sclk              (spi_sclk),
    .spi_sdi               (spi_sdi),
    .spi_sdo               (spi_sdo),
    .spi_sdo_en            (spi_sdo_en),
    .cal_valid             (cal_valid),
    .cal_value             (cal_value),
    .edge_spacing          (edge_spacing),
    .measured_bit_time     (measured_bit_time),
    .recovery_enable_bit   (recovery_enable_bit),
    .recovery_clock_select (recovery_clock_select),
    .recovery_clock_mhz    (recovery_clock_mhz),
    .filter_time_constant  (filter_time_constant),
    .clamped_bit_time      (clamped_bit_time)
  );

  wcr_spi_host host (
    .clk      (clk),
    .spi_cs_n (spi_cs_n),
    .spi_sclk (spi_sclk),
    .spi_sdi  (spi_sdi),
    .spi_sdo  (spi_sdo),
    .rd_valid (rd_valid),
    .rd_data  (rd_data)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(a, 1'b0, 8'h00, 16);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(a, 1'b1, d, 16);
  endtask : wr

  task automatic read_all;
    logic [7:0] rv [6];
    rv = '{8'h00, 8'h00, 8'h04, 8'h00, 8'ha8, 8'h98};
    for (int i = 0; i < 6; i++) begin
      rd(7'h3a + 7'(i), rv[i]);
    end
  endtask : read_all

  // registered outputs follow their inputs within two falling edges
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle

  // result watcher: each read answer is matched with the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("FAIL read data expected none seen %h", rd_data);
      end else begin
        cmp("read data", exp_q.pop_front(), rd_data);
        cmp("sdo enable", 8'h01, {7'h0, spi_sdo_en});
      end
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("FAIL watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    reset_n           = 1'b0;
    soft_reset        = 1'b0;
    restart           = 1'b0;
    cal_valid         = 1'b0;
    cal_value         = 16'h0000;
    edge_spacing      = 4'h5;
    measured_bit_time = 8'h00;
    void'($urandom(79380));
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
    read_all();
    rd(7'h40, 8'h00);
    wr(7'h3c, 8'hff);
    rd(7'h3c, 8'h0d);
    wr(7'h3d, 8'hff);
    rd(7'h3d, 8'h03);
    wr(7'h3a, 8'h5a);
    rd(7'h3a, 8'h00);
    host.xfer(7'h3e, 1'b1, 8'h11, 15);
    rd(7'h3e, 8'ha8);
    for (int s = 0; s < 3; s++) begin
      wr(7'h3c, 8'(s << 2));
      settle();
      cmp("time constant", 8'(8 << s), {2'h0, filter_time_constant});
    end
    wr(7'h3c, 8'h0c);
    for (int k = 0; k < 9; k++) begin
      edge_spacing = 4'(k + 2);
      v = (k < 2) ? 8'h20 : (k < 7) ? 8'h10 : 8'h08;
      settle();
      cmp("adaptive constant", v, {2'h0, filter_time_constant});
    end
    for (int c = 0; c < 4; c++) begin
      wr(7'h3d, 8'(c));
      settle();
      cmp("clock select", 8'(c), {6'h0, recovery_clock_select});
      cmp("clock mhz", 8'(80 >> c), {1'b0, recovery_clock_mhz});
    end
    // recommended set for a clock to baud ratio of 80 on the 40 MHz clock
    wr(7'h3d, 8'h01);
    wr(7'h3e, 8'h54);
    wr(7'h3f, 8'h4c);
    rd(7'h3e, 8'h54);
    rd(7'h3f, 8'h4c);
    lo = 8'h40 + 8'($urandom_range(63));
    hi = lo + 8'h20 + 8'($urandom_range(63));
    wr(7'h3e, hi);
    wr(7'h3f, lo);
    rd(7'h3e, hi);
    rd(7'h3f, lo);
    wr(7'h3c, 8'h01);
    settle();
    cmp("enable", 8'h01, {7'h0, recovery_enable_bit});
    for (int t = 0; t < 6; t++) begin
      v = (t == 0) ? 8'hff : (t == 1) ? 8'h00 : 8'($urandom);
      measured_bit_time = v;
      v = (v > hi) ? hi : (v < lo) ? lo : v;
      settle();
      cmp("clamped bit time", v, clamped_bit_time);
    end
    wr(7'h3c, 8'h00);
    measured_bit_time = 8'hff;
    settle();
    cmp("enable", 8'h00, {7'h0, recovery_enable_bit});
    cmp("raw bit time", 8'hff, clamped_bit_time);
    wr(7'h3c, 8'h09);
    wr(7'h3d, 8'h02);
    restart = 1'b1;
    @(negedge clk);
    restart = 1'b0;
    rd(7'h3c, 8'h09);
    rd(7'h3d, 8'h02);
    cal_value = 16'($urandom);
    cal_valid = 1'b1;
    @(negedge clk);
    cal_valid = 1'b0;
    rd(7'h3a, cal_value[15:8]);
    rd(7'h3b, cal_value[7:0]);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    read_all();
    repeat (4) @(negedge clk);
    cmp("pending reads", 8'h00, 8'(exp_q.size()));
    cmp("sdo idle", 8'h00, {7'h0, spi_sdo_en});
    end_sim();
  end
endmodule : wake_clock_recovery_config_bench

// File: testbench/wcr_spi_host.sv
`timescale 1ns/1ps
module wcr_spi_host (
  input  wire logic       clk,
  output logic            spi_cs_n,
  output logic            spi_sclk,
  output logic            spi_sdi,
  input  wire logic       spi_sdo,
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b0;
    rd_valid = 1'b0;
    rd_data  = 8'h00;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // half periods of 8 clk leave room for the pin synchronisers
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, input int nb);
    logic [15:0] fr;
    fr       = {d, w, a};
    spi_cs_n = 1'b0;
    wt(8);
    for (int i = 0; i < nb; i++) begin
      spi_sdi = fr[i];
      wt(8);
      if (i >= 8) rd_data[i-8] = spi_sdo;
      spi_sclk = 1'b1;
      wt(8);
      spi_sclk = 1'b0;
    end
    wt(8);
    spi_cs_n = 1'b1;
    // released data line shows the inverse of its last value
    spi_sdi  = ~spi_sdi;
    rd_valid = ~w;
    wt(1);
    rd_valid = 1'b0;
    wt(10);
  endtask : xfer
endmodule : wcr_spi_host
